// ### verilog/bls_pkg.sv
// Constants and types of the button and LED mode selector
`default_nettype none
package bls_pkg;
    localparam int CLOCK_HZ = 20_000_000;
    localparam int DEBOUNCE_MS = 20;
    localparam int DEBOUNCE_CYCLES = (CLOCK_HZ / 1000) * DEBOUNCE_MS;
    localparam int INITIAL_AMBER_MS = 1000;
    localparam int INITIAL_AMBER_CYCLES = (CLOCK_HZ / 1000) * INITIAL_AMBER_MS;
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_HALF_CYCLES = (CLOCK_HZ / 1000) * BLINK_HALF_MS;
    localparam int BLINKS_PER_PHASE = 5;
    localparam int CNT_W = 32;

    // LED colour code: bit 0 green, bit 1 red; both lit is amber
    localparam logic [1:0] LED_OFF = 2'h0;
    localparam logic [1:0] LED_GREEN = 2'h1;
    localparam logic [1:0] LED_RED = 2'h2;
    localparam logic [1:0] LED_AMBER = 2'h3;

    typedef enum logic [7:0] {
        BLS_ST_RESET   = 8'b0000_0001,
        BLS_ST_AMBER   = 8'b0000_0010,
        BLS_ST_RED     = 8'b0000_0100,
        BLS_ST_AMB_BL  = 8'b0000_1000,
        BLS_ST_GRN_BL  = 8'b0001_0000,
        BLS_ST_GA_BL   = 8'b0010_0000,
        BLS_ST_RA_BL   = 8'b0100_0000,
        BLS_ST_RUN     = 8'b1000_0000
    } bls_state_t;
endpackage : bls_pkg
`default_nettype wire

// ### verilog/bls_debounce.sv
// Button synchroniser and debounce filter
`default_nettype none
module bls_debounce #(
    parameter int CYCLES = bls_pkg::DEBOUNCE_CYCLES
) (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic raw,
    output var  logic level
);
    localparam int CNT_W = bls_pkg::CNT_W;

    logic sync_a;
    logic sync_b;
    logic [CNT_W-1:0] count;

    // Two-stage synchroniser; first stage read only by second
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= raw;
            sync_b <= sync_a;
        end
    end

    // Level must hold steady for CYCLES before it is accepted
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            count <= '0;
            level <= 1'b0;
        end else if (sync_b == level) begin
            count <= '0;
        end else if (count >= CNT_W'(CYCLES - 1)) begin
            count <= '0;
            level <= sync_b;
        end else begin
            count <= count + 1'b1;
        end
    end

endmodule : bls_debounce
`default_nettype wire

// ### verilog/bls_selector.sv
// Single button feed, pause and power-up maintenance selector
// What this block does; RQ11 and RQ12 are left to host and operator
// RQ1 - Press while idle green feeds next label
// RQ2 - Press while printing pauses the job
// RQ3 - Button held at power-on enters selection
// RQ4 - LED: amber, five blinks each, solid green
// RQ5 - Release during red blinks selects calibration
// RQ6 - Red action calibrates sensor, measures length
// RQ7 - Release during amber blinks selects combined action
// RQ8 - Combined action adds settings print, dump mode
// RQ9 - Release during green blinks restores defaults
// RQ10 - Release during green/amber forces black mark
// RQ11 - Host picks sensing type before calibration
// RQ12 - Operator calibrates after printer initialization
// RQ13 - Release during red/amber forces gap mode
// RQ14 - Release at solid green skips startup program
// RQ15 - Timings are parameters; initial amber selects nothing
// RQ16 - Button synchronised and debounced before edges
`default_nettype none
module bls_selector #(
    parameter int DEBOUNCE_CYCLES = bls_pkg::DEBOUNCE_CYCLES,
    parameter int AMBER_CYCLES    = bls_pkg::INITIAL_AMBER_CYCLES,
    parameter int HALF_CYCLES     = bls_pkg::BLINK_HALF_CYCLES,
    parameter int BLINKS          = bls_pkg::BLINKS_PER_PHASE
) (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       button_raw,
    input  wire logic       printing,
    input  wire logic       printer_ready,
    output var  logic [1:0] led,
    output var  logic       feed_next_label,
    output var  logic       pause_job,
    output var  logic       sensor_calibrate,
    output var  logic       measure_length,
    output var  logic       self_test_print,
    output var  logic       dump_mode,
    output var  logic       restore_defaults,
    output var  logic       force_black_mark,
    output var  logic       force_gap,
    output var  logic       skip_startup_program,
    output var  logic       normal_start,
    output var  logic       selecting
);
    localparam int CNT_W = bls_pkg::CNT_W;

    logic                 btn;
    logic                 btn_prev;
    logic                 press;
    logic                 release_ev;
    logic                 first;
    bls_pkg::bls_state_t  state;
    bls_pkg::bls_state_t  next_state;
    logic [CNT_W-1:0]     tick;
    logic [CNT_W-1:0]     blink;
    logic                 blink_on;
    logic                 half_done;
    logic                 phase_done;

    // Debounced button level
    bls_debounce #(
        .CYCLES (DEBOUNCE_CYCLES)
    ) u_deb (
        .clock   (clock),
        .sys_rst (sys_rst),
        .raw     (button_raw),
        .level   (btn)
    ); // RQ16

    // Edge detection on the filtered level
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            btn_prev <= 1'b0;
        end else begin
            btn_prev <= btn;
        end
    end
    assign press      = btn & ~btn_prev; // RQ16
    assign release_ev = ~btn & btn_prev; // RQ16

    // Power-on strap: wait out the filter before sampling held button
    logic [CNT_W-1:0] boot_cnt;
    logic             boot_done;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            boot_cnt <= '0;
        end else if (!boot_done) begin
            boot_cnt <= boot_cnt + 1'b1;
        end
    end
    // Filtered level lands two edges after the filter count; sample after
    assign boot_done = boot_cnt >= CNT_W'(DEBOUNCE_CYCLES + 2);
    assign first = (state == bls_pkg::BLS_ST_RESET) && boot_done;

    assign half_done  = tick >= CNT_W'(HALF_CYCLES - 1);
    assign phase_done = half_done && !blink_on
                        && blink >= CNT_W'(BLINKS - 1);

    // Phase sequencer
    always_comb begin
        next_state = state;
        case (state)
            bls_pkg::BLS_ST_RESET: begin
                if (first) begin
                    next_state = btn ? bls_pkg::BLS_ST_AMBER
                                     : bls_pkg::BLS_ST_RUN; // RQ3
                end
            end
            bls_pkg::BLS_ST_AMBER: begin
                if (release_ev) begin
                    next_state = bls_pkg::BLS_ST_RUN; // RQ15
                end else if (tick >= CNT_W'(AMBER_CYCLES - 1)) begin
                    next_state = bls_pkg::BLS_ST_RED; // RQ4
                end
            end
            bls_pkg::BLS_ST_RED: begin
                if (release_ev) begin
                    next_state = bls_pkg::BLS_ST_RUN;
                end else if (phase_done) begin
                    next_state = bls_pkg::BLS_ST_AMB_BL; // RQ4
                end
            end
            bls_pkg::BLS_ST_AMB_BL: begin
                if (release_ev) begin
                    next_state = bls_pkg::BLS_ST_RUN;
                end else if (phase_done) begin
                    next_state = bls_pkg::BLS_ST_GRN_BL; // RQ4
                end
            end
            bls_pkg::BLS_ST_GRN_BL: begin
                if (release_ev) begin
                    next_state = bls_pkg::BLS_ST_RUN;
                end else if (phase_done) begin
                    next_state = bls_pkg::BLS_ST_GA_BL; // RQ4
                end
            end
            bls_pkg::BLS_ST_GA_BL: begin
                if (release_ev) begin
                    next_state = bls_pkg::BLS_ST_RUN;
                end else if (phase_done) begin
                    next_state = bls_pkg::BLS_ST_RA_BL; // RQ4
                end
            end
            bls_pkg::BLS_ST_RA_BL: begin
                // Solid green is reached here, but selection ends on release
                next_state = release_ev ? bls_pkg::BLS_ST_RUN : state;
            end
            bls_pkg::BLS_ST_RUN: begin
                next_state = state;
            end
            default: begin
                next_state = bls_pkg::BLS_ST_RESET;
            end
        endcase
    end

    // Solid green after last red/amber blink, still awaiting release
    logic settled;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            settled <= 1'b0;
        end else if (state == bls_pkg::BLS_ST_RA_BL && phase_done) begin
            settled <= 1'b1; // RQ4
        end else if (state == bls_pkg::BLS_ST_RUN) begin
            settled <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state <= bls_pkg::BLS_ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Blink timing; restarts on every phase change
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tick     <= '0;
            blink    <= '0;
            blink_on <= 1'b1;
        end else if (next_state != state || settled) begin
            tick     <= '0;
            blink    <= '0;
            blink_on <= 1'b1;
        end else if (state == bls_pkg::BLS_ST_AMBER) begin
            tick <= tick + 1'b1;
        end else if (half_done) begin
            tick     <= '0;
            blink_on <= ~blink_on;
            if (!blink_on) begin
                blink <= blink + 1'b1;
            end
        end else begin
            tick <= tick + 1'b1;
        end
    end

    // LED drive; mixed phases alternate the two colours
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            led <= bls_pkg::LED_OFF;
        end else if (settled) begin
            led <= bls_pkg::LED_GREEN; // RQ4
        end else begin
            case (state)
                bls_pkg::BLS_ST_AMBER: begin
                    led <= bls_pkg::LED_AMBER; // RQ4
                end
                bls_pkg::BLS_ST_RED: begin
                    led <= blink_on ? bls_pkg::LED_RED : bls_pkg::LED_OFF;
                end
                bls_pkg::BLS_ST_AMB_BL: begin
                    led <= blink_on ? bls_pkg::LED_AMBER : bls_pkg::LED_OFF;
                end
                bls_pkg::BLS_ST_GRN_BL: begin
                    led <= blink_on ? bls_pkg::LED_GREEN : bls_pkg::LED_OFF;
                end
                bls_pkg::BLS_ST_GA_BL: begin
                    led <= blink_on ? bls_pkg::LED_GREEN : bls_pkg::LED_AMBER;
                end
                bls_pkg::BLS_ST_RA_BL: begin
                    led <= blink_on ? bls_pkg::LED_RED : bls_pkg::LED_AMBER;
                end
                bls_pkg::BLS_ST_RUN: begin
                    led <= printer_ready ? bls_pkg::LED_GREEN
                                         : bls_pkg::LED_OFF;
                end
                default: begin
                    led <= bls_pkg::LED_OFF;
                end
            endcase
        end
    end

    // One-cycle maintenance action pulses on release
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sensor_calibrate     <= 1'b0;
            measure_length       <= 1'b0;
            self_test_print      <= 1'b0;
            dump_mode            <= 1'b0;
            restore_defaults     <= 1'b0;
            force_black_mark     <= 1'b0;
            force_gap            <= 1'b0;
            skip_startup_program <= 1'b0;
        end else begin
            sensor_calibrate <= release_ev
                && (state == bls_pkg::BLS_ST_RED
                    || state == bls_pkg::BLS_ST_AMB_BL); // RQ5 RQ6 RQ7
            measure_length <= release_ev
                && (state == bls_pkg::BLS_ST_RED
                    || state == bls_pkg::BLS_ST_AMB_BL); // RQ6 RQ7
            self_test_print <= release_ev
                && state == bls_pkg::BLS_ST_AMB_BL; // RQ8
            dump_mode <= release_ev
                && state == bls_pkg::BLS_ST_AMB_BL; // RQ8
            restore_defaults <= release_ev
                && state == bls_pkg::BLS_ST_GRN_BL; // RQ9
            force_black_mark <= release_ev
                && state == bls_pkg::BLS_ST_GA_BL; // RQ10
            force_gap <= release_ev && !settled
                && state == bls_pkg::BLS_ST_RA_BL; // RQ13
            skip_startup_program <= release_ev && settled; // RQ14
        end
    end

    // Start-up indication and run-time button duties
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            normal_start    <= 1'b0;
            feed_next_label <= 1'b0;
            pause_job       <= 1'b0;
        end else begin
            normal_start <= first && !btn; // RQ3
            // Pause wins: a press mid-job never starts a feed
            pause_job <= state == bls_pkg::BLS_ST_RUN
                && press && printing; // RQ2
            feed_next_label <= state == bls_pkg::BLS_ST_RUN
                && press && !printing && printer_ready; // RQ1
        end
    end

    assign selecting = state != bls_pkg::BLS_ST_RUN
                       && state != bls_pkg::BLS_ST_RESET;

    // Sensing type choice (RQ11) and post-init calibration (RQ12)
    // are left to host and operator; the actions only carry the request.

    property p_feed_pulse;
        @(posedge clock) disable iff (sys_rst)
        (state == bls_pkg::BLS_ST_RUN && press && !printing
         && printer_ready) |=> feed_next_label;
    endproperty
    a_feed_pulse: assert property (p_feed_pulse) // RQ1
        else $error("feed not issued on idle press");

    property p_pause_no_feed;
        @(posedge clock) disable iff (sys_rst)
        (state == bls_pkg::BLS_ST_RUN && press && printing)
            |=> pause_job && !feed_next_label;
    endproperty
    a_pause_no_feed: assert property (p_pause_no_feed) // RQ2
        else $error("press during print did not pause");

    property p_held_enters;
        @(posedge clock) disable iff (sys_rst)
        (first && btn) |=> state == bls_pkg::BLS_ST_AMBER;
    endproperty
    a_held_enters: assert property (p_held_enters) // RQ3
        else $error("held button did not enter selection");

    property p_red_after_amber;
        @(posedge clock) disable iff (sys_rst)
        (state == bls_pkg::BLS_ST_AMBER && !release_ev
         && next_state != state) |=> state == bls_pkg::BLS_ST_RED;
    endproperty
    a_red_after_amber: assert property (p_red_after_amber) // RQ4
        else $error("amber not followed by red");

    property p_red_sel;
        @(posedge clock) disable iff (sys_rst)
        (release_ev && state == bls_pkg::BLS_ST_RED)
            |=> sensor_calibrate && measure_length && !self_test_print;
    endproperty
    a_red_sel: assert property (p_red_sel) // RQ5
        else $error("red release wrong action");

    property p_amber_sel;
        @(posedge clock) disable iff (sys_rst)
        (release_ev && state == bls_pkg::BLS_ST_AMB_BL)
            |=> sensor_calibrate && self_test_print && dump_mode;
    endproperty
    a_amber_sel: assert property (p_amber_sel) // RQ7
        else $error("amber release wrong action");

    property p_green_sel;
        @(posedge clock) disable iff (sys_rst)
        (release_ev && state == bls_pkg::BLS_ST_GRN_BL)
            |=> restore_defaults && !sensor_calibrate;
    endproperty
    a_green_sel: assert property (p_green_sel) // RQ9
        else $error("green release wrong action");

    property p_bm_sel;
        @(posedge clock) disable iff (sys_rst)
        (release_ev && state == bls_pkg::BLS_ST_GA_BL)
            |=> force_black_mark && !force_gap;
    endproperty
    a_bm_sel: assert property (p_bm_sel) // RQ10
        else $error("green/amber release wrong action");

    property p_skip_sel;
        @(posedge clock) disable iff (sys_rst)
        (release_ev && settled) |=> skip_startup_program && !force_gap;
    endproperty
    a_skip_sel: assert property (p_skip_sel) // RQ14
        else $error("solid green release wrong action");

    property p_initial_none;
        @(posedge clock) disable iff (sys_rst)
        (release_ev && state == bls_pkg::BLS_ST_AMBER)
            |=> !sensor_calibrate && !restore_defaults && !force_gap;
    endproperty
    a_initial_none: assert property (p_initial_none) // RQ15
        else $error("initial amber release selected action");
endmodule : bls_selector
`default_nettype wire

// ### verif/bls_operator.sv
// Operator model: one push button with contact chatter
`default_nettype none
module bls_operator (
    input  wire logic clock,
    output var  logic button_raw
);
    timeunit 1ns;
    timeprecision 1ns;

    initial button_raw = 1'b0;

    // Chatter on every press and release edge except the one hold makes; a real contact is no cleaner than this
    task automatic chatter(input logic final_level);
        button_raw = final_level;
        @(negedge clock);
        button_raw = !final_level;
        @(negedge clock);
        button_raw = final_level;
    endtask : chatter

    // Held down before power comes up
    task automatic hold();
        button_raw = 1'b1;
    endtask : hold

    task automatic release_button();
        @(negedge clock);
        chatter(1'b0);
    endtask : release_button

    // Zero length gives a glitch shorter than the filter
    task automatic press(input int n);
        @(negedge clock);
        chatter(1'b1);
        repeat (n + 1) @(negedge clock);
        chatter(1'b0);
    endtask : press
endmodule : bls_operator
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench of the button and LED mode selector
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {
        int         hold;
        logic [7:0] exp;
    } bls_row_t;

    logic        clock;
    logic        sys_rst;
    logic        button_raw;
    logic        printing;
    logic        printer_ready;
    logic [1:0]  led;
    logic [10:0] acts;
    logic        selecting;
    logic        clr;
    logic [31:0] cnt [11];
    int          n_fail;
    int          n_compared;

    // Release times sit mid-phase so a few cycles of latency do not matter
    // Exp order: calibrate, measure, self test, dump, defaults, mark, gap, skip
    // Defaults row runs first so a calibration follows it
    bls_row_t rows [6] = '{
        '{226, 8'h08},
        '{66,  8'hc0},
        '{146, 8'hf0},
        '{306, 8'h04},
        '{386, 8'h02},
        '{12,  8'h00}
    };
    int          led_t [12] = '{16, 30, 38, 110, 118, 190, 198, 270, 278,
                                350, 358, 446};
    logic [1:0]  led_e [12] = '{bls_pkg::LED_AMBER, bls_pkg::LED_RED,
        bls_pkg::LED_OFF, bls_pkg::LED_AMBER, bls_pkg::LED_OFF,
        bls_pkg::LED_GREEN, bls_pkg::LED_OFF, bls_pkg::LED_GREEN,
        bls_pkg::LED_AMBER, bls_pkg::LED_RED, bls_pkg::LED_AMBER,
        bls_pkg::LED_GREEN};

    bls_operator op (
        .clock      (clock),
        .button_raw (button_raw)
    );

    bls_selector #(
        .DEBOUNCE_CYCLES (4),
        .AMBER_CYCLES    (20),
        .HALF_CYCLES     (8)
    ) dut (
        .clock                (clock),
        .sys_rst              (sys_rst),
        .button_raw           (button_raw),
        .printing             (printing),
        .printer_ready        (printer_ready),
        .led                  (led),
        .feed_next_label      (acts[1]),
        .pause_job            (acts[0]),
        .sensor_calibrate     (acts[9]),
        .measure_length       (acts[8]),
        .self_test_print      (acts[7]),
        .dump_mode            (acts[6]),
        .restore_defaults     (acts[5]),
        .force_black_mark     (acts[4]),
        .force_gap            (acts[3]),
        .skip_startup_program (acts[2]),
        .normal_start         (acts[10]),
        .selecting            (selecting)
    );

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Counting high cycles also catches pulses wider than one cycle
    always @(posedge clock) begin
        for (int i = 0; i < 11; i++) begin
            if (sys_rst || clr) begin
                cnt[i] <= 32'h0000_0000;
            end else begin
                cnt[i] <= cnt[i] + {31'h0000_0000, acts[i]};
            end
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic power_up(input logic held);
        sys_rst = 1'b1;
        if (held) begin
            op.hold();
        end
        repeat (10) @(negedge clock);
        check({30'h0000_0000, led}, 32'h0000_0000);
        sys_rst = 1'b0;
    endtask : power_up

    task automatic clear_counts();
        @(negedge clock);
        clr = 1'b1;
        @(negedge clock);
        clr = 1'b0;
    endtask : clear_counts

    initial begin
        repeat (12000) @(posedge clock);
        n_fail++;
        report_and_stop();
    end

    initial begin
        int now;
        n_fail = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        printing = 1'b0;
        printer_ready = 1'b0;
        clr = 1'b0;
        for (int r = 0; r < 6; r++) begin
            power_up(1'b1);
            repeat (rows[r].hold) @(negedge clock);
            op.release_button();
            repeat (100) @(negedge clock);
            for (int i = 0; i < 8; i++) begin
                check(cnt[9 - i], {31'h0000_0000, rows[r].exp[7 - i]});
            end
            check(cnt[1] + cnt[0], 32'h0000_0000);
            check({31'h0000_0000, selecting}, 32'h0000_0000);
        end
        // Full sequence watched with the button held to the end
        power_up(1'b1);
        now = 0;
        for (int i = 0; i < 12; i++) begin
            repeat (led_t[i] - now) @(negedge clock);
            now = led_t[i];
            check({30'h0000_0000, led}, {30'h0000_0000, led_e[i]});
            check({31'h0000_0000, selecting}, 32'h0000_0001);
        end
        op.release_button();
        repeat (100) @(negedge clock);
        check(cnt[2], 32'h0000_0001);
        check(cnt[9] + cnt[5], 32'h0000_0000);
        // Plain power-up, then run-time presses for each status mix
        power_up(1'b0);
        repeat (30) @(negedge clock);
        check(cnt[10], 32'h0000_0001);
        for (int c = 0; c < 4; c++) begin
            printing = c[1];
            printer_ready = c[0];
            clear_counts();
            op.press(20);
            repeat (30) @(negedge clock);
            check(cnt[1], {31'h0000_0000, c == 1});
            check(cnt[0], {31'h0000_0000, c[1]});
            check({30'h0000_0000, led}, {30'h0000_0000, c[0]
                  ? bls_pkg::LED_GREEN : bls_pkg::LED_OFF});
        end
        // Glitch below the filter length must not feed
        printing = 1'b0;
        printer_ready = 1'b1;
        clear_counts();
        op.press(0);
        repeat (30) @(negedge clock);
        check(cnt[1], 32'h0000_0000);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
